// ### verif/ltc_core_model.sv
// Core fetch unit model: raises instruction fetches against the L2.
// Assumes the bench clock; requests change only at falling edges.
`default_nettype none
module ltc_core_model (
  // Clock
  input  wire logic ref_clk_in,
  // Fetch side
  output var logic  fetch_request_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Fetch pattern
  // ****************************************
  // Fetches keep coming in a sweep; the poll loop lives in L1, so none
  // of them is waited on by software
  initial begin
    fetch_request_out = 1'b0;
    forever @(negedge ref_clk_in) fetch_request_out <= ~fetch_request_out;
  end
endmodule
`default_nettype wire

// ### verif/tb_ltc_l2_tag.sv
// Bench for the L2 tag controller with a small set count.
// Assumes the core model drives fetches; all else comes from here.
`default_nettype none
module tb_ltc_l2_tag;
  timeunit 1ns;
  timeprecision 1ps;
  import ltc_pkg::*;
  // ****************************************
  // Signals and helpers
  // ****************************************
  localparam int SETS = 16;
  logic clk, rstn, gir, mce, prog, lv, al, hit, way, fr, fg;
  logic pe, te, mc, bv, col, rty;
  logic [31:0] a, b, c, la;
  logic [6:0]  off;
  ltc_bcast_t  bk;
  int failures, n_tests, n;
  ltc_l2_tag #(.SETS(SETS)) DUT (.ref_clk_in(clk), .resetn_in(rstn),
    .global_invalidate_request_in(gir), .machine_check_enable_in(mce),
    .invalidate_in_progress_out(prog), .lookup_valid_in(lv),
    .allocate_in(al), .lookup_addr_in(la), .lookup_hit_out(hit),
    .lookup_way_out(way), .lookup_offset_out(off),
    .fetch_request_in(fr), .fetch_grant_out(fg),
    .data_parity_error_in(pe), .tag_error_in(te), .machine_check_out(mc),
    .own_bcast_valid_in(bv), .own_bcast_kind_in(bk),
    .pipe_collision_in(col), .address_retry_response_out(rty));
  ltc_core_model core (.ref_clk_in(clk), .fetch_request_out(fr));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [31:0] pa(logic [12:0] t, logic [3:0] i);
    return {t, 8'h00, i, 7'($urandom)};
  endfunction
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      failures++;
    end
  endtask
  task automatic end_sim();
    if (failures == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic lk(logic [31:0] ad, logic alc, logic eh, logic ew);
    @(negedge clk) {lv, al, la} = {1'b1, alc, ad};
    @(negedge clk) {lv, al} = 2'b00;
    chk("hit", hit, eh);
    if (eh) chk("way", way, ew);
    chk("offset", off, ad[6:0]);
  endtask
  task automatic ev(logic v, logic [1:0] k, logic cl, logic p, logic e,
                    logic en);
    @(negedge clk) {bv, col, pe, te, mce} = {v, cl, p, e, en};
    bk = ltc_bcast_t'(k);
    @(negedge clk) {bv, col, pe, te} = 4'h0;
    chk("retry", rty, v & cl);
    chk("mcheck", mc, en & (p | e));
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    {rstn, gir, mce, lv, al, la, pe, te, bv, col, failures, n_tests} = 0;
    bk = LTC_BC_TLB_INVAL;
    void'($urandom(32'h4a99ac20));
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    n = $urandom;
    a = pa(13'(n), 4'(n));
    b = pa(a[31:19] ^ 13'h0001, a[10:7]);
    c = pa(a[31:19] ^ 13'h1000, a[10:7]);
    lk(a, 1'b0, 1'b0, 1'b0);
    lk(a, 1'b1, 1'b0, 1'b0);
    lk(a, 1'b0, 1'b1, 1'b0);
    lk(pa(a[31:19], a[10:7] ^ 4'h1), 1'b0, 1'b0, 1'b0);
    lk(b, 1'b1, 1'b0, 1'b0);
    lk(b, 1'b0, 1'b1, 1'b1);
    lk(a, 1'b0, 1'b1, 1'b0);
    lk(c, 1'b1, 1'b0, 1'b0);
    lk(c, 1'b0, 1'b1, 1'b1);
    lk(b, 1'b0, 1'b0, 1'b0);
    for (int k = 0; k < 12; k++) ev(1'($urandom), 2'(k), 1'($urandom),
      1'($urandom), 1'($urandom), 1'($urandom));
    for (int k = 0; k < 4; k++) ev(1'b1, 2'(k), 1'b1, 1'b0, 1'b0, 1'b0);
    ev(1'b0, 2'd0, 1'b1, 1'b1, 1'b1, 1'b0);
    #1 chk("grant", fg, fr);
    @(negedge clk) gir = 1'b1;
    #1 chk("progress", prog, 1'b1);
    @(negedge clk) {gir, lv, la} = {2'b01, a};
    n = 0;
    while (prog === 1'b1 && n < 40) begin
      n++;
      chk("grant", fg, 1'b0);
      @(negedge clk) chk("hit", hit, 1'b0);
    end
    lv = 1'b0;
    chk("sweep", n, SETS);
    if (n == 40) end_sim();
    lk(a, 1'b0, 1'b0, 1'b0);
    lk(c, 1'b0, 1'b0, 1'b0);
    // Fill twice the cache: tags 0..3 per set, LRU leaves 2 and 3
    for (int k = 0; k < 4 * SETS; k++)
      lk(pa(13'(k / SETS), 4'(k)), 1'b1, 1'b0, 1'b0);
    for (int k = 2 * SETS; k < 4 * SETS; k++)
      lk(pa(13'(k / SETS), 4'(k)), 1'b0, 1'b1, 1'(k / SETS - 2));
    lk(pa(13'h0000, 4'h0), 1'b0, 1'b0, 1'b0);
    end_sim();
  end
endmodule
`default_nettype wire

// ### verilog/ltc_l2_tag.sv
// Tag array, LRU, global invalidate, error reporting and self-snoop retry.
// Assumes one lookup or allocate per cycle from the core side.
//
// How it works
// - Physical address bits 13..24 select the cache set.
// - Tags hold address bits 0..12; a hit needs a matching valid way.
// - Address bits 25..31 give the byte within the block.
// - On allocate into a full set the least recently used way is the victim.
// - Completion of a global invalidate shows as the progress bit clearing.
// - Instruction fetches from memory are held off while invalidating.
// - L2 data parity and tag errors raise machine check when enabled.
// - Own tlb/sync/block-invalidate broadcasts may be retried on collision.
`default_nettype none
module ltc_l2_tag
  import ltc_pkg::*;
#(
  parameter int SETS = 1 << ltc_pkg::IDX_W
) (
  // Clock and reset
  input  wire logic                    ref_clk_in,
  input  wire logic                    resetn_in,
  // Control
  input  wire logic                    global_invalidate_request_in,
  input  wire logic                    machine_check_enable_in,
  output logic                         invalidate_in_progress_out,
  // Lookup / allocate
  input  wire logic                    lookup_valid_in,
  input  wire logic                    allocate_in,
  input  wire logic [ltc_pkg::PA_W-1:0] lookup_addr_in,
  output logic                         lookup_hit_out,
  output logic                         lookup_way_out,
  output logic [ltc_pkg::OFF_W-1:0]    lookup_offset_out,
  // Fetch hold-off
  input  wire logic                    fetch_request_in,
  output logic                         fetch_grant_out,
  // Errors
  input  wire logic                    data_parity_error_in,
  input  wire logic                    tag_error_in,
  output logic                         machine_check_out,
  // Self snoop
  input  wire logic                    own_bcast_valid_in,
  input  wire ltc_pkg::ltc_bcast_t     own_bcast_kind_in,
  input  wire logic                    pipe_collision_in,
  output logic                         address_retry_response_out
);
  import ltc_pkg::*;

  localparam int SET_W = $clog2(SETS);
  localparam int LEN_W = SET_W + 1;

  logic [TAG_W-1:0] tag_mem [SETS][WAYS];
  logic [WAYS-1:0]  valid_mem [SETS];
  logic [SETS-1:0]  lru_mem;   // Way to replace next
  logic [SET_W-1:0] sweep;
  logic             inval_busy;
  logic [LEN_W-1:0] busy_len;

  logic [TAG_W-1:0] addr_tag;
  logic [SET_W-1:0] addr_set;
  logic [WAYS-1:0]  way_match;
  logic             victim;

  // ****************************************
  // Address split
  // ****************************************
  assign addr_tag = lookup_addr_in[TAG_HI:TAG_LO];
  assign addr_set = SET_W'(lookup_addr_in[IDX_HI:IDX_LO]);

  for (genvar w = 0; w < WAYS; w++) begin : g_cmp
    assign way_match[w] = valid_mem[addr_set][w] &&
                          tag_mem[addr_set][w] == addr_tag;
  end

  set_index_a: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    addr_set == SET_W'(lookup_addr_in >> IDX_LO))
    else $error("set index wrong");

  // Empty way first, else LRU way
  always_comb begin
    if (!valid_mem[addr_set][0])
      victim = 1'b0;
    else if (!valid_mem[addr_set][1])
      victim = 1'b1;
    else
      victim = lru_mem[addr_set];
  end

  // ****************************************
  // Global invalidate sweep
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      inval_busy <= 1'b0;
      sweep      <= '0;
    end else if (!inval_busy && global_invalidate_request_in) begin
      inval_busy <= 1'b1;
      sweep      <= '0;
    end else if (inval_busy) begin
      sweep <= sweep + 1'b1;
      if (sweep == SET_W'(SETS - 1))
        inval_busy <= 1'b0;
    end
  end

  // Busy cycles of the running sweep; feeds the length checks only
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in)
      busy_len <= '0;
    else if (inval_busy)
      busy_len <= busy_len + 1'b1;
    else
      busy_len <= '0;
  end

  inval_start_a: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (!inval_busy && global_invalidate_request_in) |=> inval_busy)
    else $error("invalidate did not start");
  // A full sweep outlasts any delay range, so its cycles are counted
  inval_len_a: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    $fell(inval_busy) |-> busy_len == LEN_W'(SETS))
    else $error("invalidate sweep length wrong");
  inval_max_a: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    busy_len <= LEN_W'(SETS))
    else $error("invalidate sweep overran");

  // Progress shows in the same cycle as the request so software never
  // polls a stale zero.
  assign invalidate_in_progress_out =
    inval_busy | global_invalidate_request_in;
  assign fetch_grant_out =
    fetch_request_in & ~invalidate_in_progress_out;

  fetch_hold_a: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    invalidate_in_progress_out |-> !fetch_grant_out)
    else $error("fetch granted during invalidate");

  // ****************************************
  // Tag and LRU state
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      for (int s = 0; s < SETS; s++)
        valid_mem[s] <= '0;
      lru_mem <= '0;
    end else if (inval_busy) begin
      valid_mem[sweep] <= '0;
      lru_mem[sweep]   <= 1'b0;
    end else if (lookup_valid_in && !invalidate_in_progress_out) begin
      if (|way_match) begin
        lru_mem[addr_set] <= ~way_match[1];
      end else if (allocate_in) begin
        tag_mem[addr_set][victim]   <= addr_tag;
        valid_mem[addr_set][victim] <= 1'b1;
        lru_mem[addr_set]           <= ~victim;
      end
    end
  end

  lru_update_a: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (lookup_valid_in && !invalidate_in_progress_out && way_match[0])
      |=> lru_mem[$past(addr_set)])
    else $error("LRU not updated on hit");

  // Lookup answer is registered, one cycle after the request
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in) begin
      lookup_hit_out    <= 1'b0;
      lookup_way_out    <= 1'b0;
      lookup_offset_out <= '0;
    end else begin
      lookup_hit_out    <= lookup_valid_in && !invalidate_in_progress_out
                           && (|way_match);
      lookup_way_out    <= way_match[1];
      lookup_offset_out <= lookup_addr_in[OFF_HI:OFF_LO];
    end
  end

  hit_cause_a: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    lookup_hit_out |-> $past(lookup_valid_in))
    else $error("hit without lookup");
  offset_reg_a: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    ##1 lookup_offset_out == $past(lookup_addr_in[OFF_HI:OFF_LO]))
    else $error("offset field wrong");

  // ****************************************
  // Machine check and self-snoop retry
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in)
      machine_check_out <= 1'b0;
    else
      machine_check_out <= machine_check_enable_in &
        (data_parity_error_in | tag_error_in);
  end

  mchk_tag_a: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (machine_check_enable_in && tag_error_in) |=> machine_check_out)
    else $error("tag error not reported");
  mchk_parity_a: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (machine_check_enable_in && data_parity_error_in) |=> machine_check_out)
    else $error("parity error not reported");
  mchk_off_a: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    !machine_check_enable_in |=> !machine_check_out)
    else $error("machine check while disabled");

  // Every listed own broadcast kind may be retried; kept as a decode so a
  // kind that must never retry can be dropped in one place
  function automatic logic retry_kind(input ltc_bcast_t kind);
    case (kind)
      LTC_BC_TLB_INVAL, LTC_BC_TLB_SYNC,
      LTC_BC_IBLK_INVAL, LTC_BC_SYNC: retry_kind = 1'b1;
      default:                        retry_kind = 1'b0;
    endcase
  endfunction

  // Retry only on a collision
  always_ff @(posedge ref_clk_in) begin
    if (!resetn_in)
      address_retry_response_out <= 1'b0;
    else
      address_retry_response_out <= own_bcast_valid_in &
                                    retry_kind(own_bcast_kind_in) &
                                    pipe_collision_in;
  end

  retry_cause_a: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    address_retry_response_out |-> $past(own_bcast_valid_in))
    else $error("retry without own broadcast");
  retry_collide_a: assert property (
    @(posedge ref_clk_in) disable iff (!resetn_in)
    (own_bcast_valid_in && pipe_collision_in) |=> address_retry_response_out)
    else $error("colliding own broadcast not retried");
endmodule
`default_nettype wire

// ### verilog/ltc_pkg.sv
// Constants for the level-two cache tag controller.
// Assumes big-endian bit numbering of the 32-bit physical address (bit 0 = MSB).
`default_nettype none
package ltc_pkg;
  // ****************************************
  // Address layout
  // ****************************************
  localparam int PA_W        = 32;
  localparam int TAG_MSB_BE  = 0;   // Tag is PA[0:12]
  localparam int TAG_LSB_BE  = 12;
  localparam int IDX_MSB_BE  = 13;  // Index is PA[13:24]
  localparam int IDX_LSB_BE  = 24;
  localparam int OFF_MSB_BE  = 25;  // Byte offset is PA[25:31]
  localparam int OFF_LSB_BE  = 31;
  localparam int TAG_W = TAG_LSB_BE - TAG_MSB_BE + 1;
  localparam int IDX_W = IDX_LSB_BE - IDX_MSB_BE + 1;
  localparam int OFF_W = OFF_LSB_BE - OFF_MSB_BE + 1;
  // Little-endian slice positions derived from the big-endian layout
  localparam int TAG_HI = PA_W - 1 - TAG_MSB_BE;
  localparam int TAG_LO = PA_W - 1 - TAG_LSB_BE;
  localparam int IDX_HI = PA_W - 1 - IDX_MSB_BE;
  localparam int IDX_LO = PA_W - 1 - IDX_LSB_BE;
  localparam int OFF_HI = PA_W - 1 - OFF_MSB_BE;
  localparam int OFF_LO = PA_W - 1 - OFF_LSB_BE;
  localparam int WAYS   = 2;
  // ****************************************
  // Broadcast kinds snooped from own bus
  // ****************************************
  typedef enum logic [1:0] {
    LTC_BC_TLB_INVAL,
    LTC_BC_TLB_SYNC,
    LTC_BC_IBLK_INVAL,
    LTC_BC_SYNC
  } ltc_bcast_t;
endpackage
`default_nettype wire
